//--- hdl/lbsfs_map.vh
// Constants for the boost start-up and fault sequencer
`ifndef LBSFS_MAP_VH
`define LBSFS_MAP_VH

// Clock rates in kHz
`define LBSFS_REF_KHZ        50000
`define LBSFS_SW_KHZ         1200

// Times in microseconds
`define LBSFS_STEP_US        213
`define LBSFS_HALF_LIM_US    5000
`define LBSFS_CTRL_OFF_US    2500

// Soft-start shape and open-LED cycle count
`define LBSFS_RAMP_STEPS     32
`define LBSFS_OPEN_CYCLES    8

// Register byte offsets
`define LBSFS_ADDR_CFG       5'h00
`define LBSFS_ADDR_STATUS    5'h04
`define LBSFS_ADDR_IRQ_STAT  5'h08
`define LBSFS_ADDR_IRQ_MASK  5'h0c

// Config register fields and reset value
`define LBSFS_CFG_SW_ALLOW   0
`define LBSFS_CFG_RESET      32'h0000_0001

// Status register fields
`define LBSFS_ST_STATE_LSB   0
`define LBSFS_ST_REF_LSB     5
`define LBSFS_ST_HALF_BIT    11
`define LBSFS_ST_CTRL_BIT    12

// Interrupt bit positions, count and mask reset value
`define LBSFS_IRQ_OPEN       0
`define LBSFS_IRQ_UV         1
`define LBSFS_IRQ_OT         2
`define LBSFS_IRQ_CTRL_OFF   3
`define LBSFS_IRQ_RAMP_DONE  4
`define LBSFS_IRQ_W          5
`define LBSFS_IRQ_MASK_RESET 5'h00

`endif

//--- hdl/lbsfs_sync.v
// Two-flop synchroniser bank for asynchronous comparator and pin levels
`timescale 1ns/10ps
`default_nettype none
module lbsfs_sync #(
  parameter W = 5
) (
  // Clock and reset
  input  wire         i_ref_clk,
  input  wire         i_rst_n,
  input  wire         i_ce,
  // Levels
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else if (i_ce) begin
          meta_q <= i_async[g];
          sync_q <= meta_q;
        end
      end
      assign o_sync[g] = sync_q;
    end
  endgenerate
endmodule
`default_nettype wire

//--- hdl/lbsfs_seq.v
// Soft-start, current-limit and fault sequencer for an LED boost converter
//
// Behaviour
// - Switching runs at a fixed 1.2 MHz and that tick is the time base of all sequencing.
// - After enable the reference code climbs from zero to full in 32 equal steps of 213 us.
// - Each step length is a count of switching cycles, not a separate timer.
// - For 5 ms from the start of the ramp the half current limit is selected, then full.
// - Overvoltage on the switch node with feedback below half for 8 consecutive cycles is an open-LED fault.
// - An open-LED fault stops switching and latches off until the control pin is toggled.
// - The control pin held low for more than 2.5 ms shuts the device down; the host must hold it that long.
// - In shutdown the power switch stays off and no switching pulse is issued.
// - Undervoltage shuts the switch off and the device restarts by itself when it clears.
// - Over-temperature turns the device off and it resumes by itself when it clears.
// - A steady high control pin means full reference; a host PWM on it chops the reference by duty.
//
// Chosen here: the address map and the strobed register port.
`include "lbsfs_map.vh"
`timescale 1ns/10ps
`default_nettype none
module lbsfs_seq #(
  parameter STEP_TICKS = (`LBSFS_STEP_US * `LBSFS_SW_KHZ + 999) / 1000,
  parameter HALF_TICKS = (`LBSFS_HALF_LIM_US * `LBSFS_SW_KHZ + 999) / 1000,
  parameter OFF_TICKS  = (`LBSFS_CTRL_OFF_US * `LBSFS_SW_KHZ + 999) / 1000
) (
  // Clock, reset, enable
  input  wire        i_ref_clk,
  input  wire        i_rst_n,
  input  wire        i_ce,
  // Register port
  input  wire [4:0]  i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output wire [31:0] o_rdata,
  // Pin and comparator inputs
  input  wire        i_ctrl_pin,
  input  wire        i_switch_node_ovp,
  input  wire        i_feedback_sense_low,
  input  wire        i_input_undervoltage_lockout,
  input  wire        i_over_temp,
  // Converter controls
  output wire        o_switch_en,
  output wire        o_cycle_start,
  output wire        o_ilim_half,
  output wire [5:0]  o_ref_code,
  output wire [5:0]  o_ref_chop,
  // Interrupt
  output wire        o_irq
);

  // One-hot states
  localparam [4:0] ST_OFF   = 5'b0_0001;
  localparam [4:0] ST_RAMP  = 5'b0_0010;
  localparam [4:0] ST_RUN   = 5'b0_0100;
  localparam [4:0] ST_HOLD  = 5'b0_1000;
  localparam [4:0] ST_LATCH = 5'b1_0000;

  // Integer forms, cut to counter width on purpose below
  localparam integer PH_INC_I    = `LBSFS_SW_KHZ;
  localparam integer PH_MOD_I    = `LBSFS_REF_KHZ;
  localparam integer REF_FULL_I  = `LBSFS_RAMP_STEPS;
  localparam integer OPEN_LAST_I = `LBSFS_OPEN_CYCLES - 1;
  localparam integer STEP_LAST_I = STEP_TICKS - 1;
  localparam integer HALF_LAST_I = HALF_TICKS - 1;
  localparam integer OFF_CNT_I   = OFF_TICKS;

  localparam [16:0] PH_INC    = PH_INC_I[16:0];
  localparam [16:0] PH_MOD    = PH_MOD_I[16:0];
  localparam [5:0]  REF_FULL  = REF_FULL_I[5:0];
  localparam [3:0]  OPEN_LAST = OPEN_LAST_I[3:0];
  localparam [8:0]  STEP_LAST = STEP_LAST_I[8:0];
  localparam [12:0] HALF_LAST = HALF_LAST_I[12:0];
  localparam [12:0] OFF_CNT   = OFF_CNT_I[12:0];

  // Synchronised levels
  wire [4:0] sync_lv;
  wire       s_ctrl;
  wire       s_ovp;
  wire       s_fbl;
  wire       s_uv;
  wire       s_ot;

  lbsfs_sync #(
    .W (5)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_async   ({i_over_temp, i_input_undervoltage_lockout, i_feedback_sense_low,
                 i_switch_node_ovp, i_ctrl_pin}),
    .o_sync    (sync_lv)
  );

  assign s_ctrl = sync_lv[0];
  assign s_ovp  = sync_lv[1];
  assign s_fbl  = sync_lv[2];
  assign s_uv   = sync_lv[3];
  assign s_ot   = sync_lv[4];

  // Registers
  reg [16:0] phase_q;
  reg        tick_q;
  reg [12:0] low_cnt_q;
  reg [4:0]  state_q;
  reg [4:0]  state_d;
  reg [8:0]  step_cnt_q;
  reg [5:0]  ref_q;
  reg [12:0] half_cnt_q;
  reg        half_q;
  reg [3:0]  open_cnt_q;
  reg        seen_low_q;
  reg        sw_en_q;
  reg        cyc_q;
  reg [5:0]  chop_q;
  reg [31:0] cfg_q;
  reg [4:0]  irq_stat_q;
  reg [4:0]  irq_mask_q;
  reg [31:0] rdata_q;

  // Fractional divider: 1.2 MHz tick from the reference clock
  wire [16:0] phase_sum = phase_q + PH_INC;
  wire        phase_wrap = (phase_sum >= PH_MOD);

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_q <= 17'h0_0000;
      tick_q  <= 1'b0;
    end else if (i_ce) begin
      phase_q <= phase_wrap ? (phase_sum - PH_MOD) : phase_sum;
      tick_q  <= phase_wrap;
    end
  end

  // Control pin low-time measure
  wire ctrl_off = (low_cnt_q > OFF_CNT);

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_cnt_q <= 13'h0000;
    end else if (i_ce) begin
      if (s_ctrl) begin
        low_cnt_q <= 13'h0000;
      end else if (tick_q && !ctrl_off) begin
        low_cnt_q <= low_cnt_q + 13'h0001;
      end
    end
  end

  // Fault and event terms
  wire active     = state_q[1] | state_q[2];
  wire supply_bad = s_uv | s_ot;
  wire open_fault = tick_q && s_ovp && s_fbl && (open_cnt_q == OPEN_LAST);
  wire step_end   = tick_q && (step_cnt_q == STEP_LAST);
  wire ramp_done  = state_q[1] && step_end && (ref_q == REF_FULL - 6'd1);
  wire rel_latch  = seen_low_q && s_ctrl && !supply_bad;

  // Next state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (s_ctrl && !ctrl_off && !supply_bad) begin
          state_d = ST_RAMP;
        end
      end
      ST_RAMP, ST_RUN: begin
        if (ctrl_off) begin
          state_d = ST_OFF;
        end else if (supply_bad) begin
          state_d = ST_HOLD;
        end else if (open_fault) begin
          state_d = ST_LATCH;
        end else if (ramp_done) begin
          state_d = ST_RUN;
        end
      end
      ST_HOLD: begin
        if (ctrl_off) begin
          state_d = ST_OFF;
        end else if (!supply_bad) begin
          state_d = ST_RAMP;
        end
      end
      ST_LATCH: begin
        if (rel_latch) begin
          state_d = ST_RAMP;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end

  wire start_ramp = (state_d == ST_RAMP) && (state_q != ST_RAMP);

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_OFF;
    end else if (i_ce) begin
      state_q <= state_d;
    end
  end

  // Toggle detect for leaving the latched state
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seen_low_q <= 1'b0;
    end else if (i_ce) begin
      if (state_q != ST_LATCH) begin
        seen_low_q <= 1'b0;
      end else if (!s_ctrl) begin
        seen_low_q <= 1'b1;
      end
    end
  end

  // Reference ramp
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      step_cnt_q <= 9'h000;
      ref_q      <= 6'h00;
    end else if (i_ce) begin
      if (start_ramp || !active) begin
        step_cnt_q <= 9'h000;
        ref_q      <= 6'h00;
      end else if (state_q == ST_RAMP && tick_q) begin
        if (step_end) begin
          step_cnt_q <= 9'h000;
          ref_q      <= ref_q + 6'h01;
        end else begin
          step_cnt_q <= step_cnt_q + 9'h001;
        end
      end
    end
  end

  // Half current limit interval
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      half_cnt_q <= 13'h0000;
      half_q     <= 1'b1;
    end else if (i_ce) begin
      if (start_ramp || !active) begin
        half_cnt_q <= 13'h0000;
        half_q     <= 1'b1;
      end else if (half_q && tick_q) begin
        if (half_cnt_q == HALF_LAST) begin
          half_q <= 1'b0;
        end else begin
          half_cnt_q <= half_cnt_q + 13'h0001;
        end
      end
    end
  end

  // Open-LED consecutive cycle counter
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      open_cnt_q <= 4'h0;
    end else if (i_ce) begin
      if (!active || start_ramp) begin
        open_cnt_q <= 4'h0;
      end else if (tick_q) begin
        if (s_ovp && s_fbl) begin
          if (open_cnt_q != OPEN_LAST) begin
            open_cnt_q <= open_cnt_q + 4'h1;
          end
        end else begin
          open_cnt_q <= 4'h0;
        end
      end
    end
  end

  // Switch drive and reference outputs
  wire run_next = (state_d == ST_RAMP || state_d == ST_RUN) &&
                  cfg_q[`LBSFS_CFG_SW_ALLOW];

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sw_en_q <= 1'b0;
      cyc_q   <= 1'b0;
      chop_q  <= 6'h00;
    end else if (i_ce) begin
      sw_en_q <= run_next;
      cyc_q   <= run_next && phase_wrap;
      chop_q  <= s_ctrl ? ref_q : 6'h00;
    end
  end

  // Interrupt events
  wire [4:0] irq_ev;
  assign irq_ev[`LBSFS_IRQ_OPEN]      = active && open_fault;
  assign irq_ev[`LBSFS_IRQ_UV]        = active && s_uv;
  assign irq_ev[`LBSFS_IRQ_OT]        = active && s_ot;
  assign irq_ev[`LBSFS_IRQ_CTRL_OFF]  = (state_d == ST_OFF) && (state_q != ST_OFF);
  assign irq_ev[`LBSFS_IRQ_RAMP_DONE] = ramp_done && !ctrl_off && !supply_bad && !open_fault;

  // Register writes
  wire wr_cfg  = i_wr && (i_addr == `LBSFS_ADDR_CFG);
  wire wr_stat = i_wr && (i_addr == `LBSFS_ADDR_IRQ_STAT);
  wire wr_mask = i_wr && (i_addr == `LBSFS_ADDR_IRQ_MASK);
  wire [4:0] clr_bits = wr_stat ? i_wdata[4:0] : 5'h00;

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_q      <= `LBSFS_CFG_RESET;
      irq_stat_q <= 5'h00;
      irq_mask_q <= `LBSFS_IRQ_MASK_RESET;
    end else if (i_ce) begin
      if (wr_cfg) begin
        cfg_q <= {31'h0000_0000, i_wdata[`LBSFS_CFG_SW_ALLOW]};
      end
      if (wr_mask) begin
        irq_mask_q <= i_wdata[4:0];
      end
      irq_stat_q <= (irq_stat_q & ~clr_bits) | irq_ev;
    end
  end

  // Register reads
  reg [31:0] rd_val;
  always @* begin
    rd_val = 32'h0000_0000;
    case (i_addr)
      `LBSFS_ADDR_CFG: begin
        rd_val = cfg_q;
      end
      `LBSFS_ADDR_STATUS: begin
        rd_val[`LBSFS_ST_STATE_LSB +: 5] = state_q;
        rd_val[`LBSFS_ST_REF_LSB +: 6]   = ref_q;
        rd_val[`LBSFS_ST_HALF_BIT]       = half_q;
        rd_val[`LBSFS_ST_CTRL_BIT]       = s_ctrl;
      end
      `LBSFS_ADDR_IRQ_STAT: begin
        rd_val[4:0] = irq_stat_q;
      end
      `LBSFS_ADDR_IRQ_MASK: begin
        rd_val[4:0] = irq_mask_q;
      end
      default: begin
        rd_val = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_ce) begin
      rdata_q <= i_rd ? rd_val : 32'h0000_0000;
    end
  end

  // Outputs
  assign o_rdata       = rdata_q;
  assign o_switch_en   = sw_en_q;
  assign o_cycle_start = cyc_q;
  assign o_ilim_half   = half_q;
  assign o_ref_code    = ref_q;
  assign o_ref_chop    = chop_q;
  assign o_irq         = |(irq_stat_q & irq_mask_q);

endmodule
`default_nettype wire

//--- testbench/lbsfs_seq_checker.sv
// Concurrent checks on the sequencer top-level ports
`timescale 1ns/10ps
`default_nettype none
module lbsfs_seq_checker #(
  parameter STEP_TICKS = 256,
  parameter HALF_TICKS = 6000,
  parameter OFF_TICKS  = 3000
) (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  // Inputs watched
  input  wire logic        i_rd,
  input  wire logic        i_ctrl_pin,
  input  wire logic        i_switch_node_ovp,
  input  wire logic        i_feedback_sense_low,
  input  wire logic        i_input_undervoltage_lockout,
  input  wire logic        i_over_temp,
  // Outputs watched
  input  wire logic [31:0] o_rdata,
  input  wire logic        o_switch_en,
  input  wire logic        o_cycle_start,
  input  wire logic        o_ilim_half,
  input  wire logic [5:0]  o_ref_code
);
  localparam int TK = 42;
  logic [15:0] low_q;
  logic [15:0] open_q;
  logic [7:0]  gap_q;
  // Cycle counters for low pin, open condition and tick gap
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_q  <= 16'h0000;
      open_q <= 16'h0000;
      gap_q  <= 8'h00;
    end else if (i_ce) begin
      low_q  <= i_ctrl_pin ? 16'h0000 : low_q + {15'h0000, ~&low_q};
      open_q <= (i_switch_node_ovp && i_feedback_sense_low) ? open_q + 16'h0001 : 16'h0000;
      gap_q  <= (o_cycle_start || !o_switch_en) ? 8'h00 : gap_q + 8'h01;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n || !i_ce);
  AST_CS_EN: assert property (o_cycle_start |-> o_switch_en)
    else $error("cycle start while switching is off");
  AST_GAP: assert property (o_switch_en |-> gap_q < 8'd43)
    else $error("switching tick gap too long");
  AST_TICK: assert property (o_cycle_start |=> !o_cycle_start [*8])
    else $error("switching ticks too close");
  AST_REF_STEP: assert property (o_ref_code != $past(o_ref_code)
    |-> o_ref_code == $past(o_ref_code) + 6'h01 || o_ref_code == 6'h00)
    else $error("reference code jumped");
  AST_REF_MAX: assert property (o_ref_code <= 6'h20)
    else $error("reference code above full scale");
  AST_START: assert property ($rose(o_switch_en) |-> o_ilim_half && o_ref_code == 6'h00)
    else $error("start without ramp and half limit");
  AST_UV: assert property (i_input_undervoltage_lockout [*5] |-> !o_switch_en)
    else $error("switching during undervoltage");
  AST_OT: assert property (i_over_temp [*5] |-> !o_switch_en)
    else $error("switching during over-temperature");
  AST_OFF: assert property (low_q > (OFF_TICKS + 2) * TK + 4 |-> !o_switch_en)
    else $error("no shutdown after long low pin");
  AST_OPEN: assert property (open_q > 10 * TK + 4 |-> !o_switch_en)
    else $error("no open fault after persistent condition");
  AST_RDATA: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
    else $error("read data outside answer cycle");
endmodule
bind lbsfs_seq lbsfs_seq_checker #(
  .STEP_TICKS(STEP_TICKS), .HALF_TICKS(HALF_TICKS), .OFF_TICKS(OFF_TICKS)
) lbsfs_seq_checker_i (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_rd(i_rd), .i_ctrl_pin(i_ctrl_pin),
  .i_switch_node_ovp(i_switch_node_ovp), .i_feedback_sense_low(i_feedback_sense_low),
  .i_input_undervoltage_lockout(i_input_undervoltage_lockout), .i_over_temp(i_over_temp),
  .o_rdata(o_rdata), .o_switch_en(o_switch_en), .o_cycle_start(o_cycle_start),
  .o_ilim_half(o_ilim_half), .o_ref_code(o_ref_code)
);
`default_nettype wire

//--- testbench/lbsfs_host_model.sv
// Host pin driver and analog comparator model
`timescale 1ns/10ps
`default_nettype none
module lbsfs_host_model (
  // Clock and bench commands
  input  wire logic i_ref_clk,
  input  wire logic i_on,
  input  wire logic i_open,
  input  wire logic i_uv,
  input  wire logic i_ot,
  input  wire logic i_switch_en,
  // Pin and comparator levels
  output logic      o_ctrl_pin,
  output logic      o_ovp,
  output logic      o_fbl,
  output logic      o_uv,
  output logic      o_ot
);
  // Levels move at the clock edge; switch node only rises while switching
  always @(posedge i_ref_clk) begin
    o_ctrl_pin <= i_on;
    o_ovp      <= i_open && i_switch_en;
    o_fbl      <= i_open;
    o_uv       <= i_uv;
    o_ot       <= i_ot;
  end
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the boost start-up and fault sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        i_ref_clk, i_rst_n, i_wr, i_rd, on, open, uv, ot, ce;
  logic        ctrl, ovp, fbl, uvs, ots, o_switch_en, o_cycle_start, o_ilim_half, o_irq;
  logic [4:0]  i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [5:0]  o_ref_code, o_ref_chop;
  int          n_errors, checks, n, h;
  lbsfs_seq #(.STEP_TICKS(4), .HALF_TICKS(20), .OFF_TICKS(10)) lbsfs_seq_i (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ctrl_pin(ctrl),
    .i_switch_node_ovp(ovp), .i_feedback_sense_low(fbl), .i_input_undervoltage_lockout(uvs),
    .i_over_temp(ots), .o_switch_en(o_switch_en), .o_cycle_start(o_cycle_start),
    .o_ilim_half(o_ilim_half), .o_ref_code(o_ref_code), .o_ref_chop(o_ref_chop), .o_irq(o_irq));
  lbsfs_host_model lbsfs_host_model_i (
    .i_ref_clk(i_ref_clk), .i_on(on), .i_open(open), .i_uv(uv), .i_ot(ot),
    .i_switch_en(o_switch_en), .o_ctrl_pin(ctrl), .o_ovp(ovp), .o_fbl(fbl), .o_uv(uvs),
    .o_ot(ots));
  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    @(posedge i_ref_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 chk("rdata", e, o_rdata);
  endtask
  task automatic wsw(input logic v);
    n = 0;
    while (o_switch_en !== v && n < 3000) begin
      @(posedge i_ref_clk);
      #1 n++;
    end
    chk("switch_en", v, o_switch_en);
    if (n >= 3000) test_done();
  endtask
  initial begin
    {i_rst_n, i_wr, i_rd, on, open, uv, ot} = 7'h00;
    ce = 1'b1;
    i_addr = 5'h00;
    i_wdata = 32'h0000_0000;
    n_errors = 0;
    checks = 0;
    repeat (4) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    rd(5'h00, 32'h0000_0001);
    rd(5'h04, 32'h0000_0801);
    rd(5'h0c, 32'h0000_0000);
    rd(5'h10, 32'h0000_0000);
    wr(5'h0c, 32'h0000_001f);
    on <= 1'b1;
    wsw(1'b1);
    chk("half", 1, o_ilim_half);
    chk("ref", 0, o_ref_code);
    n = 0;
    h = 0;
    while (o_ref_code !== 6'h20 && n < 8000) begin
      @(posedge i_ref_clk);
      #1 n++;
      if (o_ilim_half === 1'b1) h = n;
    end
    chk("ramp time", 1, n > 5270 && n < 5400);
    chk("half time", 1, h > 780 && h < 880);
    chk("irq", 1, o_irq);
    rd(5'h08, 32'h0000_0010);
    wr(5'h08, 32'h0000_0010);
    chk("irq", 0, o_irq);
    rd(5'h04, 32'h0000_1404);
    @(posedge i_ref_clk);
    ce <= 1'b0;
    on <= 1'b0;
    repeat (600) @(posedge i_ref_clk);
    on <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    ce <= 1'b1;
    #1 chk("switch_en", 1, o_switch_en);
    rd(5'h04, 32'h0000_1404);
    on <= 1'b0;
    repeat (300) @(posedge i_ref_clk);
    #1 chk("chop", 0, o_ref_chop);
    chk("switch_en", 1, o_switch_en);
    on <= 1'b1;
    repeat (10) @(posedge i_ref_clk);
    #1 chk("chop", 32'h20, o_ref_chop);
    on <= 1'b0;
    wsw(1'b0);
    chk("off time", 1, n > 415 && n < 510);
    rd(5'h08, 32'h0000_0008);
    wr(5'h08, 32'h0000_0008);
    on <= 1'b1;
    wsw(1'b1);
    for (int k = 0; k < 2; k++) begin
      uv <= (k == 0);
      ot <= (k == 1);
      wsw(1'b0);
      rd(5'h08, (k == 0) ? 32'h0000_0002 : 32'h0000_0004);
      wr(5'h08, 32'h0000_0006);
      uv <= 1'b0;
      ot <= 1'b0;
      wsw(1'b1);
      chk("half", 1, o_ilim_half);
      chk("ref", 0, o_ref_code);
    end
    open <= 1'b1;
    wsw(1'b0);
    chk("open time", 1, n > 290 && n < 400);
    rd(5'h08, 32'h0000_0001);
    open <= 1'b0;
    repeat (600) @(posedge i_ref_clk);
    #1 chk("switch_en", 0, o_switch_en);
    wr(5'h0c, 32'h0000_0000);
    chk("irq", 0, o_irq);
    wr(5'h0c, 32'h0000_001f);
    chk("irq", 1, o_irq);
    wr(5'h08, 32'h0000_0001);
    chk("irq", 0, o_irq);
    on <= 1'b0;
    repeat (50) @(posedge i_ref_clk);
    on <= 1'b1;
    wsw(1'b1);
    chk("half", 1, o_ilim_half);
    wr(5'h00, 32'h0000_0000);
    wsw(1'b0);
    rd(5'h00, 32'h0000_0000);
    rd(5'h04, 32'h0000_1802);
    test_done();
  end
endmodule
`default_nettype wire
